// File: hw/can_timing_pkg.sv
// Constants, register map and types shared by the CAN bit-timing block.
//
// How it works
// - One time quantum lasts two times (prescaler plus one) clock periods.
// - Each bit is sync, propagation, phase one and phase two, whole quanta each.
// - Sync segment is exactly one quantum; edges are expected inside it.
// - Propagation segment is programmable from one to eight quanta.
// - Phase segment one is one to eight quanta, lengthened on resync.
// - Phase segment two is two to eight quanta, shortened on resync.
// - Triple sample off: one sample between phase segments one and two.
// - Triple sample on: two more samples half a quantum apart, majority vote.
// - Bit level needs two quanta after sampling, so phase two is at least two.
// - Only recessive-to-dominant edges synchronise; rising edges are ignored.
// - Hard sync restarts the bit counter at the sync segment.
// - Edges outside sync segment resynchronise by adjusting the phase segments.
// - Any resync adjustment is limited to the jump width, one to four quanta.
// - While arbitrating, each sampled bit is compared with the transmitted bit.
// - Start of frame is reported only if the level taken at the sample point is dominant (the majority vote with triple sample on).
package can_timing_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] OFF_TIMING_CONFIG_ONE = 8'h00;
  localparam logic [7:0] OFF_TIMING_CONFIG_TWO = 8'h04;
  localparam logic [7:0] OFF_TIMING_CONFIG_THREE = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // Field positions.
  localparam int CFG1_PRESCALER_LSB = 0;
  localparam int CFG1_JUMP_LSB = 6;
  localparam int CFG2_PROP_LSB = 0;
  localparam int CFG2_PH1_LSB = 3;
  localparam int CFG2_TRIPLE_BIT = 6;
  localparam int CFG3_PH2_LSB = 0;
  localparam int CONTROL_ENABLE_BIT = 0;

  // Values after reset.
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [7:0] CFG2_RESET = 8'h00;
  localparam logic [7:0] CFG3_RESET = 8'h01;
  localparam logic CONTROL_ENABLE_RESET = 1'b0;

  // Counts.
  localparam logic [3:0] SYNC_QUANTA = 4'h1;
  localparam logic [3:0] BIT_RESOLVE_QUANTA = 4'h2;
  localparam logic [3:0] IDLE_RECESSIVE_BITS = 4'hb;

  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_PROP = 2'b01,
    SEG_PH1 = 2'b10,
    SEG_PH2 = 2'b11
  } segment_e;

  // Fields hold the programmed value minus one, except the prescaler.
  typedef struct packed {
    logic [5:0] quantum_prescaler;
    logic [1:0] jump_width;
    logic [2:0] propagation_segment;
    logic [2:0] phase_segment_one;
    logic [2:0] phase_segment_two;
    logic triple_sample_select;
  } timing_s;

endpackage

// File: hw/can_bit_timing.sv
// CAN bit-timing engine with AHB-Lite register access.
`timescale 1ns/1ns
`default_nettype none
module can_bit_timing (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // CAN link side
  input wire logic rx_level,
  input wire logic tx_level,
  input wire logic arbitrating,
  output logic sample_strobe,
  output logic rx_bit,
  output logic sof_pulse,
  output logic bit_mismatch,
  output logic bus_idle
);

  can_timing_pkg::timing_s cfg;
  logic enable;
  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;
  logic [7:0] sof_count;
  logic [6:0] q_cnt;
  logic [3:0] tq_in_seg;
  can_timing_pkg::segment_e seg;
  logic [2:0] ph1_ext;
  logic [2:0] ph2_cut;
  logic resync_done;
  logic sof_pending;
  logic [3:0] recessive_run;
  logic rx_prev;
  logic tq_rx;
  logic half_rx;
  logic tq_end;
  logic half_point;
  logic edge_fall;
  logic hard_sync;
  logic late_edge;
  logic early_edge;
  logic early_restart;
  logic restart;
  logic seg_done;
  logic sample_point;
  logic voted;
  logic [3:0] jump_len;
  logic [3:0] ph2_len;
  logic [3:0] seg_limit;
  logic [4:0] late_err;
  logic [3:0] early_err;
  logic [31:0] read_value;
  // Register bus: zero wait states, always OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_valid <= hsel && hready && htrans[1] && (hsize == 3'h2);
      dp_write <= hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_comb begin
    read_value = 32'h00000000;
    case (haddr[7:0])
      can_timing_pkg::OFF_TIMING_CONFIG_ONE: begin
        read_value[7:0] = {cfg.jump_width, cfg.quantum_prescaler};
      end
      can_timing_pkg::OFF_TIMING_CONFIG_TWO: begin
        read_value[7:0] = {1'b0, cfg.triple_sample_select, cfg.phase_segment_one,
                           cfg.propagation_segment};
      end
      can_timing_pkg::OFF_TIMING_CONFIG_THREE: begin
        read_value[7:0] = {5'h00, cfg.phase_segment_two};
      end
      can_timing_pkg::OFF_CONTROL: begin
        read_value[0] = enable;
      end
      can_timing_pkg::OFF_STATUS: begin
        read_value[15:0] = {sof_count, 3'h0, sof_pending, seg, bus_idle, rx_bit};
      end
      default: begin
        read_value = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      hrdata <= read_value;
    end
  end
  // Timing fields should only be changed while the engine is disabled.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= {can_timing_pkg::CFG1_RESET[5:0], can_timing_pkg::CFG1_RESET[7:6],
              can_timing_pkg::CFG2_RESET[2:0], can_timing_pkg::CFG2_RESET[5:3],
              can_timing_pkg::CFG3_RESET[2:0], can_timing_pkg::CFG2_RESET[6]};
      enable <= can_timing_pkg::CONTROL_ENABLE_RESET;
    end else if (dp_valid && dp_write) begin
      case (dp_addr)
        can_timing_pkg::OFF_TIMING_CONFIG_ONE: begin
          cfg.quantum_prescaler <= hwdata[can_timing_pkg::CFG1_PRESCALER_LSB +: 6];
          cfg.jump_width <= hwdata[can_timing_pkg::CFG1_JUMP_LSB +: 2];
        end
        can_timing_pkg::OFF_TIMING_CONFIG_TWO: begin
          cfg.propagation_segment <= hwdata[can_timing_pkg::CFG2_PROP_LSB +: 3];
          cfg.phase_segment_one <= hwdata[can_timing_pkg::CFG2_PH1_LSB +: 3];
          cfg.triple_sample_select <= hwdata[can_timing_pkg::CFG2_TRIPLE_BIT];
        end
        can_timing_pkg::OFF_TIMING_CONFIG_THREE: begin
          cfg.phase_segment_two <= hwdata[can_timing_pkg::CFG3_PH2_LSB +: 3];
        end
        can_timing_pkg::OFF_CONTROL: begin
          enable <= hwdata[can_timing_pkg::CONTROL_ENABLE_BIT];
        end
        default: begin
        end
      endcase
    end
  end
  // Quantum timing and segment lengths.
  assign tq_end = (q_cnt == {cfg.quantum_prescaler, 1'b1});
  assign half_point = (q_cnt == {1'b0, cfg.quantum_prescaler});
  assign jump_len = {2'b00, cfg.jump_width} + 4'h1;
  // A programmed value below the resolve time is raised to it.
  assign ph2_len = ({1'b0, cfg.phase_segment_two} + 4'h1 < can_timing_pkg::BIT_RESOLVE_QUANTA) ?
                   can_timing_pkg::BIT_RESOLVE_QUANTA :
                   {1'b0, cfg.phase_segment_two} + 4'h1;

  always_comb begin
    case (seg)
      can_timing_pkg::SEG_SYNC: seg_limit = can_timing_pkg::SYNC_QUANTA;
      can_timing_pkg::SEG_PROP: seg_limit = {1'b0, cfg.propagation_segment} + 4'h1;
      can_timing_pkg::SEG_PH1: begin
        seg_limit = {1'b0, cfg.phase_segment_one} + 4'h1 + {1'b0, ph1_ext};
      end
      can_timing_pkg::SEG_PH2: seg_limit = ph2_len - {1'b0, ph2_cut};
      default: seg_limit = can_timing_pkg::SYNC_QUANTA;
    endcase
  end

  assign seg_done = tq_end && (tq_in_seg + 4'h1 >= seg_limit);
  assign sample_point = seg_done && (seg == can_timing_pkg::SEG_PH1);
  // Synchronisation edges.
  assign edge_fall = rx_prev && !rx_level;
  assign hard_sync = enable && edge_fall && bus_idle && !sof_pending;
  assign late_edge = enable && edge_fall && !bus_idle && !resync_done &&
                     (seg == can_timing_pkg::SEG_PROP || seg == can_timing_pkg::SEG_PH1);
  assign early_edge = enable && edge_fall && !bus_idle && !resync_done &&
                      (seg == can_timing_pkg::SEG_PH2);
  assign late_err = (seg == can_timing_pkg::SEG_PROP) ? {1'b0, tq_in_seg} + 5'h01 :
                    {2'b00, cfg.propagation_segment} + {1'b0, tq_in_seg} + 5'h02;
  assign early_err = ph2_len - tq_in_seg;
  // An early edge within the jump width simply starts the next bit at the edge.
  assign early_restart = early_edge && (early_err <= jump_len);
  assign restart = hard_sync || early_restart;

  assign voted = cfg.triple_sample_select ?
                 ((tq_rx & half_rx) | (tq_rx & rx_level) | (half_rx & rx_level)) :
                 rx_level;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_prev <= 1'b1;
      tq_rx <= 1'b1;
      half_rx <= 1'b1;
    end else begin
      rx_prev <= enable ? rx_level : 1'b1;
      if (tq_end) begin
        tq_rx <= rx_level;
      end
      if (half_point) begin
        half_rx <= rx_level;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_cnt <= 7'h00;
    end else if (!enable || restart || tq_end) begin
      q_cnt <= 7'h00;
    end else begin
      q_cnt <= q_cnt + 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg <= can_timing_pkg::SEG_SYNC;
      tq_in_seg <= 4'h0;
    end else if (!enable || restart) begin
      seg <= can_timing_pkg::SEG_SYNC;
      tq_in_seg <= 4'h0;
    end else if (seg_done) begin
      tq_in_seg <= 4'h0;
      case (seg)
        can_timing_pkg::SEG_SYNC: seg <= can_timing_pkg::SEG_PROP;
        can_timing_pkg::SEG_PROP: seg <= can_timing_pkg::SEG_PH1;
        can_timing_pkg::SEG_PH1: seg <= can_timing_pkg::SEG_PH2;
        default: seg <= can_timing_pkg::SEG_SYNC;
      endcase
    end else if (tq_end) begin
      tq_in_seg <= tq_in_seg + 4'h1;
    end
  end

  // Phase adjustments live for one bit and are dropped at the next sync segment.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph1_ext <= 3'h0;
      ph2_cut <= 3'h0;
    end else if (!enable || restart || (seg_done && seg == can_timing_pkg::SEG_PH2)) begin
      ph1_ext <= 3'h0;
      ph2_cut <= 3'h0;
    end else if (late_edge) begin
      ph1_ext <= (late_err < {1'b0, jump_len}) ? late_err[2:0] : jump_len[2:0];
    end else if (early_edge) begin
      ph2_cut <= jump_len[2:0];
    end
  end

  // One synchronisation per bit, re-armed at the sample point.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resync_done <= 1'b0;
    end else if (!enable || sample_point) begin
      resync_done <= 1'b0;
    end else if (hard_sync || late_edge || early_edge) begin
      resync_done <= 1'b1;
    end
  end

  // Idle detection and start-of-frame glitch filtering.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_idle <= 1'b0;
      recessive_run <= 4'h0;
      sof_pending <= 1'b0;
      sof_pulse <= 1'b0;
      sof_count <= 8'h00;
    end else begin
      sof_pulse <= 1'b0;
      if (!enable) begin
        bus_idle <= 1'b0;
        recessive_run <= 4'h0;
        sof_pending <= 1'b0;
      end else if (hard_sync) begin
        sof_pending <= 1'b1;
      end else if (sample_point) begin
        if (sof_pending) begin
          sof_pending <= 1'b0;
          if (!voted) begin
            sof_pulse <= 1'b1;
            sof_count <= sof_count + 8'h01;
            bus_idle <= 1'b0;
            recessive_run <= 4'h0;
          end
        end else if (voted) begin
          if (recessive_run + 4'h1 >= can_timing_pkg::IDLE_RECESSIVE_BITS) begin
            bus_idle <= 1'b1;
          end else begin
            recessive_run <= recessive_run + 4'h1;
          end
        end else begin
          recessive_run <= 4'h0;
        end
      end
    end
  end

  // Sampled bit and arbitration compare.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_strobe <= 1'b0;
      rx_bit <= 1'b1;
      bit_mismatch <= 1'b0;
    end else begin
      sample_strobe <= sample_point && enable;
      bit_mismatch <= sample_point && enable && arbitrating && (voted != tx_level);
      if (sample_point && enable) begin
        rx_bit <= voted;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_quantum_wrap;
    enable && tq_end && !restart |=> q_cnt == 7'h00 ##1
      (q_cnt == 7'h01 || $past(restart) || !$past(enable));
  endproperty
  a_quantum_wrap: assert property (p_quantum_wrap) else $error("quantum count did not wrap");

  property p_sync_one;
    enable && seg == can_timing_pkg::SEG_SYNC && tq_end && !restart |=>
      seg == can_timing_pkg::SEG_PROP;
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("sync segment longer than one quantum");

  property p_prop_range;
    seg == can_timing_pkg::SEG_PROP |-> tq_in_seg <= {1'b0, cfg.propagation_segment};
  endproperty
  a_prop_range: assert property (p_prop_range) else $error("propagation segment overrun");

  property p_jump_limit;
    enable |-> ({1'b0, ph1_ext} <= jump_len) && ({1'b0, ph2_cut} <= jump_len);
  endproperty
  a_jump_limit: assert property (p_jump_limit) else $error("adjustment beyond jump width");

  property p_ph2_floor;
    seg == can_timing_pkg::SEG_PH2 && seg_done |->
      tq_in_seg + {1'b0, ph2_cut} + 4'h1 >= can_timing_pkg::BIT_RESOLVE_QUANTA;
  endproperty
  a_ph2_floor: assert property (p_ph2_floor) else $error("phase two below resolve time");

  property p_hard_restart;
    hard_sync |=> seg == can_timing_pkg::SEG_SYNC && q_cnt == 7'h00 && sof_pending;
  endproperty
  a_hard_restart: assert property (p_hard_restart) else $error("hard sync did not restart");

  property p_falling_only;
    restart || late_edge || early_edge |-> $past(rx_level) && !rx_level;
  endproperty
  a_falling_only: assert property (p_falling_only) else $error("sync on wrong edge");

  property p_sof_dominant;
    sof_pulse |-> !rx_bit && sample_strobe && !bus_idle;
  endproperty
  a_sof_dominant: assert property (p_sof_dominant) else $error("start of frame without dominant");

  property p_single_sample;
    sample_point && enable && !cfg.triple_sample_select |=> rx_bit == $past(rx_level);
  endproperty
  a_single_sample: assert property (p_single_sample) else $error("single sample mismatch");

  property p_mismatch;
    sample_point && enable && arbitrating |=> bit_mismatch == (rx_bit != $past(tx_level));
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("arbitration compare wrong");

endmodule
`default_nettype wire

// File: verif/can_node_model.sv
// Behavioural far-side CAN node that drives the received bus level.
`timescale 1ns/1ns
`default_nettype none
module can_node_model (
  // Clock
  input wire logic hclk,
  // Received bus level, 1 is recessive
  output logic rx_level
);
  // The bus rests recessive while no node transmits.
  initial rx_level = 1'b1;

  // This bus has no propagation delay, so every sample point lies after the round trip.
  // The level is changed just after a rising edge, then held for n edges.
  task automatic drive(input logic v, input int n);
    rx_level <= v;
    repeat (n) @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// File: verif/can_bit_timing_bench.sv
// Self-checking bench for the CAN bit-timing block.
`timescale 1ns/1ns
`default_nettype none
module can_bit_timing_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic tx_level = 1'b1;
  logic arbitrating = 1'b0;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire rx_level;
  wire sample_strobe;
  wire rx_bit;
  wire sof_pulse;
  wire bit_mismatch;
  wire bus_idle;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] rd;

  can_bit_timing uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_level(rx_level), .tx_level(tx_level),
    .arbitrating(arbitrating), .sample_strobe(sample_strobe), .rx_bit(rx_bit),
    .sof_pulse(sof_pulse), .bit_mismatch(bit_mismatch), .bus_idle(bus_idle)
  );

  can_node_model node (.hclk(hclk), .rx_level(rx_level));

  always #5 hclk = ~hclk;

  always @(posedge hclk) begin
    cyc <= cyc + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The master waits for hready however long it takes; only the watchdog ends a hang.
  task automatic wait_ready;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    check(q, e);
  endtask

  task automatic setup(input int p, input int pr, input int p1, input int f2, input int j,
                       input logic tri3);
    // Timing fields are only changed while the engine is stopped.
    wr(8'h0c, 32'h0);
    wr(8'h00, {24'h0, 2'(j - 1), 6'(p)});
    wr(8'h04, {25'h0, tri3, 3'(p1 - 1), 3'(pr - 1)});
    wr(8'h08, {29'h0, 3'(f2)});
    wr(8'h0c, 32'h1);
  endtask

  task automatic next_strobe(output int t);
    do begin
      @(posedge hclk);
      #1;
    end while (sample_strobe !== 1'b1);
    t = cyc;
  endtask

  task automatic wait_idle;
    do begin
      @(posedge hclk);
      #1;
    end while (bus_idle !== 1'b1);
  endtask

  task automatic t_regs;
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h08, 32'h1);
    rd_chk(8'h0c, 32'h0);
    wr(8'h14, 32'hffffffff);
    rd_chk(8'h14, 32'h0);
    wr(8'h04, 32'h7f);
    // A read straight after a write to the same register would already see the new value.
    @(posedge hclk);
    rd_chk(8'h04, 32'h7f);
    check({hresp, hreadyout}, 2'b01);
  endtask

  // Strobe spacing is one whole bit; a phase two field of zero still gives two quanta.
  task automatic t_period;
    int pv[4] = '{0, 1, 2, 63};
    int sv[4] = '{1, 8, 2, 1};
    int qv[4] = '{1, 8, 1, 1};
    int fv[4] = '{1, 7, 0, 1};
    int t0;
    int t1;
    for (int i = 0; i < 4; i++) begin
      setup(pv[i], sv[i], qv[i], fv[i], 1, 1'b0);
      next_strobe(t0);
      next_strobe(t0);
      next_strobe(t1);
      check(t1 - t0, 2 * (pv[i] + 1) * (2 + sv[i] + qv[i] + (fv[i] == 0 ? 1 : fv[i])));
    end
  endtask

  task automatic t_sof;
    int n;
    setup(0, 1, 1, 1, 1, 1'b0);
    wait_idle();
    @(posedge hclk);
    node.drive(1'b0, 1);
    node.drive(1'b1, 0);
    repeat (30) begin
      @(posedge hclk);
      #1;
      check(sof_pulse, 1'b0);
    end
    check(bus_idle, 1'b1);
    @(posedge hclk);
    node.drive(1'b0, 0);
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (sof_pulse !== 1'b1 && n < 20);
    check(n, 1 + 2 * 3);
    check({rx_bit, bus_idle}, 2'b00);
    node.drive(1'b1, 0);
  endtask

  // Recessive only over the last two clocks of phase one: the vote keeps dominant.
  task automatic t_triple;
    int t;
    for (int s = 0; s < 2; s++) begin
      setup(1, 1, 1, 1, 1, s[0]);
      wait_idle();
      @(posedge hclk);
      node.drive(1'b0, 11);
      node.drive(1'b1, 0);
      next_strobe(t);
      check({sof_pulse, rx_bit}, s ? 2'b10 : 2'b01);
    end
  endtask

  task automatic t_resync;
    int t0;
    int t1;
    int t2;
    int t3;
    setup(1, 1, 1, 3, 1, 1'b0);
    wait_idle();
    arbitrating <= 1'b1;
    tx_level <= 1'b0;
    @(posedge hclk);
    node.drive(1'b0, 0);
    next_strobe(t0);
    check({sof_pulse, rx_bit, bit_mismatch}, 3'b100);
    @(posedge hclk);
    node.drive(1'b1, 0);
    next_strobe(t1);
    check(t1 - t0, 28);
    check({rx_bit, bit_mismatch}, 2'b11);
    repeat (24) @(posedge hclk);
    node.drive(1'b0, 0);
    next_strobe(t2);
    check(t2 - t1, 28 + 4);
    @(posedge hclk);
    node.drive(1'b1, 4);
    node.drive(1'b0, 0);
    next_strobe(t3);
    check(t3 - t2, 28 - 4);
    arbitrating <= 1'b0;
    node.drive(1'b1, 0);
  endtask

  initial begin
    repeat (10) @(posedge hclk);
    #1;
    check({sample_strobe, rx_bit, sof_pulse, bit_mismatch, bus_idle, hreadyout}, 6'h10);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_period();
    t_sof();
    t_triple();
    t_resync();
    wait_idle();
    ahb(1'b0, 8'h10, 32'h0, rd);
    check({rd[15:8], rd[1:0]}, {8'h03, 2'b11});
    end_sim();
  end

  // The whole run needs well under ten thousand cycles.
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
